/* common/tpso_pkg.sv */
package tpso_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ          = 250;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int PCLK_MHZ_10      = 10;
  localparam int PCLK_MHZ_20      = 20;
  localparam int PCLK_MHZ_40      = 40;
  localparam int PCLK_MHZ_80      = 80;
  localparam int TRIG_HOLD_NS     = 250;
  localparam int TRIG_HOLD_CYC    = (TRIG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_NS       = 2000;
  localparam int STRETCH_CYC      = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_NS          = 15750;
  localparam int CONV_CYC         = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRST_START_NS   = 89750;
  localparam int FIRST_START_CYC  = (FIRST_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NEXT_FRAME_NS    = 17000;
  localparam int NEXT_FRAME_CYC   = (NEXT_FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] FEND_TICKS = 4'h2;
  localparam logic [7:0] RX_GAP_CYC = 8'h40;
  // ****************************************************************
  // frame geometry and pixel format
  // ****************************************************************
  localparam logic [6:0]  ROW_FIRST    = 7'h41;
  localparam logic [6:0]  ROW_LAST     = 7'h06;
  localparam logic [7:0]  COL_FIRST    = 8'h04;
  localparam logic [7:0]  COL_LAST     = 8'hA3;
  localparam logic [8:0]  ROW_BYTES_1  = 9'h0A0;
  localparam logic [8:0]  ROW_BYTES_2  = 9'h140;
  localparam logic [13:0] FRAME_PIX    = 14'h2580;
  localparam logic [11:0] PIX_ALL_ONES = 12'hFFF;
  typedef enum logic [1:0] {
    FMT_MSB_LSB = 2'b00,
    FMT_LSB_MSB = 2'b01,
    FMT_8BIT    = 2'b10
  } tpso_fmt_t;
  typedef enum logic [1:0] {
    RATE_10 = 2'b00,
    RATE_20 = 2'b01,
    RATE_40 = 2'b10,
    RATE_80 = 2'b11
  } tpso_rate_t;
  // ****************************************************************
  // host registers
  // ****************************************************************
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STAT   = 8'h04;
  localparam logic [7:0]  REG_PIXC   = 8'h08;
  localparam int          CTRL_TRIG  = 0;
  localparam int          CTRL_GATED = 1;
  localparam int          CTRL_FMT   = 2;
  localparam int          CTRL_POL   = 4;
  localparam int          CTRL_OVFD0 = 5;
  localparam int          CTRL_ONES  = 6;
  localparam int          CTRL_XOVF  = 7;
  localparam logic [7:0]  CTRL_RST   = 8'h90;

  // cycles of the system clock per half pixel-clock period
  function automatic logic [3:0] half_cycles(tpso_rate_t r);
    unique case (r)
      RATE_10: half_cycles = 4'(CLK_MHZ / (2 * PCLK_MHZ_10));
      RATE_20: half_cycles = 4'(CLK_MHZ / (2 * PCLK_MHZ_20));
      RATE_40: half_cycles = 4'(CLK_MHZ / (2 * PCLK_MHZ_40));
      RATE_80: half_cycles = 4'(CLK_MHZ / (2 * PCLK_MHZ_80));
    endcase
  endfunction
endpackage

/* common/tpso_camera_data_port.sv */
`timescale 1ns/100ps
interface tpso_camera_data_port;
  logic       pixel_clock_out;
  logic       frame_valid_line;
  logic       row_valid_line;
  logic       overflow_or_frame_end_line;
  logic [7:0] data;
  logic       shutter;
  modport dev (
    output pixel_clock_out,
    output frame_valid_line,
    output row_valid_line,
    output overflow_or_frame_end_line,
    output data,
    input  shutter
  );
  modport host (
    input  pixel_clock_out,
    input  frame_valid_line,
    input  row_valid_line,
    input  overflow_or_frame_end_line,
    input  data,
    output shutter
  );
endinterface

/* rtl/tpso_dev_end.sv */
`timescale 1ns/100ps
// Summary of operation
// - frame rows 65 down to 6, cols 4-163
// - pixel is 12-bit signed plus overflow flag
// - started frame always completes, receiver keeps up
// - pixel clock selectable 10/20/40/80 MHz
// - continuous mode drives sync, data, free clock
// - outputs change on active pixel-clock edge
// - receiver samples on non-active edge
// - receiver drops data during blanking
// - frame-valid then row-valid on successive edges
// - third line: overflow, or frame end
// - gated mode: data and clock, sync lines too if sync_in_gated
// - gated clock runs in rows plus extra
// - one trigger starts a cycle of frames
// - host holds trigger 250 ns, releases early
// - next frame starts 17 us after readout
// - auto-run or late trigger repeats cycle
// - row stretch adds 2 us per conversion
// - three byte formats, 8-bit sends top bits
// - high-first: bits 11-4, then 3-0,000,flag
// - low-first: 3-0,000,flag, then bits 11-4
// - optional flag on data line 0
// - optional all-ones for overflowed pixel
module tpso_dev_end #(
  parameter int unsigned ACQ_CYC       = tpso_pkg::FIRST_START_CYC,
  parameter int unsigned FRAME_GAP_CYC = tpso_pkg::NEXT_FRAME_CYC,
  parameter int unsigned CONV_CYC      = tpso_pkg::CONV_CYC
) (
  // clock and reset
  input  logic                   clock,
  input  logic                   sys_rst,
  input  logic                   ce,
  // link
  tpso_camera_data_port.dev      link,
  // configuration
  input  tpso_pkg::tpso_rate_t   rate,
  input  logic                   pol_high,
  input  logic                   gated,
  input  logic                   sync_in_gated,
  input  logic [3:0]             gate_extra,
  input  logic                   xsync_is_ovf,
  input  tpso_pkg::tpso_fmt_t    fmt,
  input  logic                   ovf_on_d0,
  input  logic                   force_ones,
  input  logic                   row_stretch,
  input  logic [3:0]             frames_per_cycle,
  // acquisition control
  input  logic                   sw_shutter,
  input  logic                   auto_run,
  // pixel source
  input  logic [11:0]            pix_value,
  input  logic                   pix_ovf,
  output logic                   pix_next,
  output logic                   busy
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    DS_IDLE   = 3'b000,
    DS_WAIT   = 3'b001,
    DS_FSTART = 3'b010,
    DS_ROW    = 3'b011,
    DS_RGAP   = 3'b100,
    DS_FEND   = 3'b101
  } tpso_dev_st_t;

  typedef struct packed {
    tpso_dev_st_t st;
    logic [3:0]   half_cnt;
    logic         ph;
    logic         pclk;
    logic [15:0]  wait_cnt;
    logic [3:0]   fend_cnt;
    logic [3:0]   ext;
    logic [3:0]   frame;
    logic [6:0]   row;
    logic [7:0]   col;
    logic         phase;
    logic         done;
    logic [11:0]  pix;
    logic         ovf;
    logic         fv;
    logic         rv;
    logic         xl;
    logic         fvo;
    logic         rvo;
    logic         xlo;
    logic [7:0]   data;
    logic         pix_next;
    logic         busy;
    logic         rerun;
    logic         shut_s1;
    logic         shut_s2;
    logic         shut_prev;
  } tpso_dev_state_t;

  tpso_dev_state_t q;
  tpso_dev_state_t d;

  // ****************************************************************
  // byte packing
  // ****************************************************************
  function automatic logic [7:0] enc(tpso_pkg::tpso_fmt_t f, logic [11:0] v, logic o,
                                     logic second, logic d0);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = {v[11:5], d0 ? o : v[4]};
    lo = {v[3:0], 3'h0, o};
    unique case (f)
      tpso_pkg::FMT_MSB_LSB: enc = second ? lo : hi;
      tpso_pkg::FMT_LSB_MSB: enc = second ? hi : lo;
      default:               enc = v[11:4];
    endcase
  endfunction

  logic        trig;
  logic        act;
  logic        run;
  logic [11:0] v;

  always_comb begin
    d           = q;
    d.pix_next  = 1'b0;
    d.shut_s1   = link.shutter;
    d.shut_s2   = q.shut_s1;
    d.shut_prev = q.shut_s2;
    trig        = sw_shutter | (q.shut_s2 & ~q.shut_prev);
    act         = 1'b0;
    v           = (force_ones & pix_ovf) ? tpso_pkg::PIX_ALL_ONES : pix_value;
    // ****************************************************************
    // pixel clock divider
    // ****************************************************************
    if (q.half_cnt == 4'h0) begin
      d.half_cnt = tpso_pkg::half_cycles(rate) - 4'h1;
      d.ph       = ~q.ph;
      act        = (d.ph == pol_high);
    end else begin
      d.half_cnt = q.half_cnt - 4'h1;
    end
    if (q.wait_cnt != 16'h0000) begin
      d.wait_cnt = q.wait_cnt - 16'h0001;
    end
    if (q.st == DS_IDLE && trig) begin
      d.st       = DS_WAIT;
      d.wait_cnt = 16'(ACQ_CYC);
      d.frame    = 4'h0;
      d.rerun    = 1'b0;
    end
    // ****************************************************************
    // frame sequencer, steps on active edges only
    // ****************************************************************
    if (act) begin
      if (q.ext != 4'h0 && q.st != DS_ROW) begin
        d.ext = q.ext - 4'h1;
      end
      unique case (q.st)
        DS_IDLE: begin
        end
        DS_WAIT: begin
          if (q.wait_cnt == 16'h0000) begin
            d.st = DS_FSTART;
          end
        end
        DS_FSTART: begin
          d.st  = DS_ROW;
          d.fv  = 1'b1;
          d.row = tpso_pkg::ROW_FIRST;
          d.col = tpso_pkg::COL_FIRST;
        end
        DS_ROW: begin
          if (q.done) begin
            d.done = 1'b0;
            d.rv   = 1'b0;
            d.xl   = 1'b0;
            d.data = 8'h00;
            d.ext  = gate_extra;
            d.col  = tpso_pkg::COL_FIRST;
            if (q.row == tpso_pkg::ROW_LAST) begin
              d.st       = DS_FEND;
              d.fend_cnt = tpso_pkg::FEND_TICKS;
              d.xl       = ~xsync_is_ovf;
            end else begin
              d.row      = q.row - 7'h01;
              d.st       = DS_RGAP;
              d.wait_cnt = row_stretch ? 16'(CONV_CYC + tpso_pkg::STRETCH_CYC)
                                       : 16'(CONV_CYC);
            end
          end else begin
            d.rv = 1'b1;
            if (!q.phase) begin
              d.pix      = v;
              d.ovf      = pix_ovf;
              d.data     = enc(fmt, v, pix_ovf, 1'b0, ovf_on_d0);
              d.xl       = xsync_is_ovf & pix_ovf;
              d.pix_next = 1'b1;
              d.phase    = (fmt != tpso_pkg::FMT_8BIT);
            end else begin
              d.data  = enc(fmt, q.pix, q.ovf, 1'b1, ovf_on_d0);
              d.phase = 1'b0;
            end
            if (q.phase || fmt == tpso_pkg::FMT_8BIT) begin
              if (q.col == tpso_pkg::COL_LAST) begin
                d.done = 1'b1;
              end else begin
                d.col = q.col + 8'h01;
              end
            end
          end
        end
        DS_RGAP: begin
          if (q.wait_cnt == 16'h0000) begin
            d.st = DS_ROW;
          end
        end
        DS_FEND: begin
          if (q.fend_cnt == 4'h0) begin
            d.fv    = 1'b0;
            d.xl    = 1'b0;
            d.frame = q.frame + 4'h1;
            if (d.frame < frames_per_cycle) begin
              d.st       = DS_WAIT;
              d.wait_cnt = 16'(FRAME_GAP_CYC);
            end else if (q.rerun || auto_run) begin
              d.st       = DS_WAIT;
              d.wait_cnt = 16'(FRAME_GAP_CYC);
              d.frame    = 4'h0;
              d.rerun    = 1'b0;
            end else begin
              d.st = DS_IDLE;
            end
          end else begin
            d.fend_cnt = q.fend_cnt - 4'h1;
          end
        end
        default: begin
          d.st = DS_IDLE;
        end
      endcase
    end
    // late trigger during the final row pair repeats the cycle
    if ((q.st == DS_ROW || q.st == DS_RGAP) && q.frame == frames_per_cycle - 4'h1 &&
        q.row <= tpso_pkg::ROW_LAST + 7'h01 && (auto_run || q.shut_s2)) begin
      d.rerun = 1'b1;
    end
    // ****************************************************************
    // clock gating and output staging
    // ****************************************************************
    run    = ~gated | (d.st == DS_ROW) | (d.ext != 4'h0);
    d.pclk = run ? d.ph : ~pol_high;
    d.fvo  = d.fv & (~gated | sync_in_gated);
    d.rvo  = d.rv & (~gated | sync_in_gated);
    d.xlo  = d.xl & (~gated | sync_in_gated);
    d.busy = (d.st != DS_IDLE);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign link.pixel_clock_out            = q.pclk;
  assign link.frame_valid_line           = q.fvo;
  assign link.row_valid_line             = q.rvo;
  assign link.overflow_or_frame_end_line = q.xlo;
  assign link.data                       = q.data;
  assign pix_next                        = q.pix_next;
  assign busy                            = q.busy;
endmodule

/* rtl/tpso_host_end.sv */
`timescale 1ns/100ps
module tpso_host_end (
  // clock and reset
  input  logic               clock,
  input  logic               sys_rst,
  input  logic               ce,
  // apb slave
  input  logic               psel,
  input  logic               penable,
  input  logic               pwrite,
  input  logic [7:0]         paddr,
  input  logic [31:0]        pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // link
  tpso_camera_data_port.host link,
  // captured pixels
  output logic               pix_valid,
  output logic [11:0]        pix_value,
  output logic               pix_ovf,
  output logic               frame_done
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic        prev_pclk;
    logic        prev_fv;
    logic [7:0]  ctrl;
    logic [7:0]  trig_cnt;
    logic        shutter;
    logic        phase;
    logic [7:0]  first;
    logic [8:0]  byte_cnt;
    logic [7:0]  gap_cnt;
    logic [13:0] pix_cnt;
    logic [13:0] last_pix;
    logic [15:0] frames;
    logic        pix_valid;
    logic [11:0] pix_value;
    logic        pix_ovf;
    logic        frame_done;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tpso_host_state_t;

  tpso_host_state_t q;
  tpso_host_state_t d;

  logic       pclk_s;
  logic       fv_s;
  logic       rv_s;
  logic       xl_s;
  logic [7:0] b;
  logic       edge_na;
  logic       take;
  logic       gated;
  logic       pol;
  logic [1:0] fmt;
  logic [8:0] row_bytes;
  logic [7:0] msb;
  logic [7:0] lsb;

  always_comb begin
    d            = q;
    d.s1         = {link.pixel_clock_out, link.frame_valid_line, link.row_valid_line,
                    link.overflow_or_frame_end_line, link.data};
    d.s2         = q.s1;
    {pclk_s, fv_s, rv_s, xl_s, b} = q.s2;
    d.prev_pclk  = pclk_s;
    d.prev_fv    = fv_s;
    d.pix_valid  = 1'b0;
    d.frame_done = 1'b0;
    d.pready     = 1'b0;
    d.pslverr    = 1'b0;
    gated        = q.ctrl[tpso_pkg::CTRL_GATED];
    pol          = q.ctrl[tpso_pkg::CTRL_POL];
    fmt          = q.ctrl[tpso_pkg::CTRL_FMT +: 2];
    row_bytes    = (fmt == tpso_pkg::FMT_8BIT) ? tpso_pkg::ROW_BYTES_1 : tpso_pkg::ROW_BYTES_2;
    msb          = (fmt == tpso_pkg::FMT_MSB_LSB) ? q.first : b;
    lsb          = (fmt == tpso_pkg::FMT_MSB_LSB) ? b : q.first;
    // ****************************************************************
    // sampling on the non-active pixel-clock edge
    // ****************************************************************
    edge_na = (pclk_s == ~pol) && (q.prev_pclk == pol);
    take    = edge_na && (gated ? (q.byte_cnt < row_bytes) : (fv_s && rv_s));
    if (edge_na) begin
      d.gap_cnt = 8'h00;
    end else if (q.gap_cnt != tpso_pkg::RX_GAP_CYC) begin
      d.gap_cnt = q.gap_cnt + 8'h01;
    end
    if ((gated && q.gap_cnt == tpso_pkg::RX_GAP_CYC - 8'h01) ||
        (!gated && edge_na && !rv_s)) begin
      d.byte_cnt = 9'h000;
      d.phase    = 1'b0;
    end
    if (take) begin
      d.byte_cnt = q.byte_cnt + 9'h001;
      if (fmt == tpso_pkg::FMT_8BIT) begin
        d.pix_valid = 1'b1;
        d.pix_value = {b, 4'h0};
        d.pix_ovf   = ~gated & q.ctrl[tpso_pkg::CTRL_XOVF] & xl_s;
      end else if (!q.phase) begin
        d.first = b;
        d.phase = 1'b1;
      end else begin
        d.phase     = 1'b0;
        d.pix_valid = 1'b1;
        d.pix_value = {msb, lsb[7:4]};
        d.pix_ovf   = lsb[0] | (q.ctrl[tpso_pkg::CTRL_OVFD0] & msb[0]);
      end
      if (q.ctrl[tpso_pkg::CTRL_ONES] && d.pix_value == tpso_pkg::PIX_ALL_ONES) begin
        d.pix_ovf = 1'b1;
      end
    end
    if (d.pix_valid) begin
      if (q.pix_cnt == tpso_pkg::FRAME_PIX - 14'h0001) begin
        d.pix_cnt    = 14'h0000;
        d.last_pix   = tpso_pkg::FRAME_PIX;
        d.frames     = q.frames + 16'h0001;
        d.frame_done = 1'b1;
      end else begin
        d.pix_cnt = q.pix_cnt + 14'h0001;
      end
    end else if (!gated && q.prev_fv && !fv_s && q.pix_cnt != 14'h0000) begin
      d.last_pix = q.pix_cnt;
      d.pix_cnt  = 14'h0000;
    end
    // ****************************************************************
    // trigger pulse
    // ****************************************************************
    if (q.trig_cnt != 8'h00) begin
      d.trig_cnt = q.trig_cnt - 8'h01;
    end
    // ****************************************************************
    // register access
    // ****************************************************************
    if (psel && !penable) begin
      d.pready = 1'b1;
      unique case (paddr)
        tpso_pkg::REG_CTRL: d.prdata = {24'h000000, q.ctrl};
        tpso_pkg::REG_STAT: d.prdata = {q.frames, 2'h0, q.last_pix};
        tpso_pkg::REG_PIXC: d.prdata = {18'h00000, q.pix_cnt};
        default: begin
          d.prdata  = 32'h00000000;
          d.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && q.pready && pwrite && paddr == tpso_pkg::REG_CTRL) begin
      d.ctrl = pwdata[7:0] & ~8'(1 << tpso_pkg::CTRL_TRIG);
      if (pwdata[tpso_pkg::CTRL_TRIG]) begin
        d.trig_cnt = 8'(tpso_pkg::TRIG_HOLD_CYC);
      end
    end
    d.shutter = (d.trig_cnt != 8'h00);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q      <= '0;
      q.ctrl <= tpso_pkg::CTRL_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign link.shutter = q.shutter;
  assign pix_valid    = q.pix_valid;
  assign pix_value    = q.pix_value;
  assign pix_ovf      = q.pix_ovf;
  assign frame_done   = q.frame_done;
endmodule

/* dv/tpso_link_properties.sv */
`timescale 1ns/100ps
module tpso_link_properties (
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // link lines
  input wire logic       pixel_clock_out,
  input wire logic       frame_valid_line,
  input wire logic       row_valid_line,
  input wire logic [7:0] data,
  input wire logic       shutter
);
  logic [6:0] rows_q;
  logic [7:0] hold_q;
  logic       rv_q;
  // rows per frame, trigger high time
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rows_q <= 7'h00;
      hold_q <= 8'h00;
      rv_q   <= 1'h0;
    end else begin
      rv_q   <= row_valid_line;
      hold_q <= !shutter ? 8'h00 : hold_q + 8'((hold_q != 8'hFF));
      rows_q <= !frame_valid_line ? 7'h00 : rows_q + 7'((row_valid_line && !rv_q));
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  rv_in_frame_a: assert property (row_valid_line |-> frame_valid_line)
    else $error("row valid outside frame");
  fv_leads_a: assert property ($rose(frame_valid_line) |-> !row_valid_line)
    else $error("row valid rose with frame valid");
  rv_follows_a: assert property ($rose(frame_valid_line) |-> ##[1:30] $rose(row_valid_line))
    else $error("row valid late after frame valid");
  data_edge_a: assert property ($changed(data) |-> $rose(pixel_clock_out))
    else $error("data changed off active edge");
  clock_runs_a: assert property ($rose(pixel_clock_out) |-> ##[1:24] $fell(pixel_clock_out))
    else $error("pixel clock stopped");
  row_gap_a: assert property ($fell(row_valid_line) |-> ##[1:120] (row_valid_line || !frame_valid_line))
    else $error("frame stalled between rows");
  fv_trails_a: assert property ($fell(frame_valid_line) |-> !$past(row_valid_line))
    else $error("frame ended inside a row");
  row_count_a: assert property ($fell(frame_valid_line) |-> rows_q == 7'h3C)
    else $error("wrong row count in frame");
  shutter_hold_a: assert property ($fell(shutter) |-> hold_q >= 8'h3F)
    else $error("trigger released too early");
endmodule

/* dv/test_tof_pixel_stream_output.sv */
`timescale 1ns/100ps
module test_tof_pixel_stream_output;
  // ************
  // bench
  // ************
  logic                 clock, sys_rst, xovf, d0, ones, sw_shut, psel, penable, pwrite;
  logic                 pready, pslverr, e_err, s_next, busy, h_valid, h_ovf, f_done, rv_q;
  logic                 ce = 1'h1;
  logic                 pol = 1'h1;
  logic                 run = 1'h0;
  logic [3:0]           nfr = 4'h1;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [11:0]          k, h_val, s_val, hv;
  logic [12:0]          m, e;
  logic [12:0]          exp_q[$];
  tpso_pkg::tpso_rate_t rate = tpso_pkg::RATE_80;
  tpso_pkg::tpso_fmt_t  fmt;
  int                   err_total, n_compared;
  tpso_camera_data_port link();
  assign s_val = k * 12'h025;
  assign hv = (ones && k[2]) ? 12'hFFF : s_val;
  assign m = (fmt == tpso_pkg::FMT_8BIT) ? 13'h0FF0 : (d0 ? 13'h1FEF : 13'h1FFF);
  tpso_dev_end #(.ACQ_CYC(20), .FRAME_GAP_CYC(20), .CONV_CYC(20)) u_tpso_dev_end (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .link(link), .rate(rate), .pol_high(pol),
    .gated(1'h0), .sync_in_gated(1'h0), .gate_extra(4'h0), .xsync_is_ovf(xovf), .fmt(fmt),
    .ovf_on_d0(d0), .force_ones(ones), .row_stretch(1'h0), .frames_per_cycle(nfr),
    .sw_shutter(sw_shut), .auto_run(run), .pix_value(s_val), .pix_ovf(k[2]),
    .pix_next(s_next), .busy(busy));
  tpso_host_end u_tpso_host_end (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link), .pix_valid(h_valid), .pix_value(h_val),
    .pix_ovf(h_ovf), .frame_done(f_done));
  tpso_link_properties u_tpso_link_properties (
    .clock(clock), .sys_rst(sys_rst), .pixel_clock_out(link.pixel_clock_out),
    .frame_valid_line(link.frame_valid_line), .row_valid_line(link.row_valid_line),
    .data(link.data), .shutter(link.shutter));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    e_err = pslverr;
    if (pready !== 1'h1) begin
      err_total++;
      test_done();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  // pixel source and capture check
  always @(posedge clock) begin
    rv_q <= link.row_valid_line;
    if (link.row_valid_line === 1'h1 && rv_q === 1'h0) begin
      if (fmt == tpso_pkg::FMT_MSB_LSB) chk(link.data, {hv[11:5], d0 ? k[2] : hv[4]});
      else if (fmt == tpso_pkg::FMT_LSB_MSB) chk(link.data, {hv[3:0], 3'h0, k[2]});
      else chk(link.data, hv[11:4]);
    end
    if (s_next === 1'h1) begin
      exp_q.push_back({k[2], hv});
      k <= k + 12'h001;
    end
    if (h_valid === 1'h1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 13'h0;
      chk({h_ovf, h_val} & m, e & m);
    end
  end
  task automatic t_regs();
    apb(1'h0, tpso_pkg::REG_CTRL, 32'h0);
    chk(rd, {24'h0, tpso_pkg::CTRL_RST});
    apb(1'h0, 8'h0C, 32'h0);
    chk(e_err, 1'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_frame(input tpso_pkg::tpso_fmt_t f, input logic o1, input logic dz);
    int n;
    n = 0;
    while (busy !== 1'h0 && n < 5000) begin
      @(posedge clock);
      n++;
    end
    if (busy !== 1'h0) begin
      err_total++;
      test_done();
    end
    fmt <= f;
    ones <= o1;
    d0 <= dz;
    apb(1'h1, tpso_pkg::REG_CTRL, {24'h0, xovf, o1, dz, pol, f, 1'h0, 1'h1});
    n = 0;
    while (f_done !== 1'h1 && n < 70000) begin
      @(posedge clock);
      n++;
    end
    if (f_done !== 1'h1) begin
      err_total++;
      test_done();
    end
    apb(1'h0, tpso_pkg::REG_STAT, 32'h0);
    chk(rd[13:0], tpso_pkg::FRAME_PIX);
    chk(exp_q.size(), 32'h0);
  endtask
  task automatic t_abort();
    int   n;
    logic p;
    nfr <= 4'h2;
    run <= 1'h1;
    xovf <= 1'h0;
    fmt <= tpso_pkg::FMT_LSB_MSB;
    ones <= 1'h1;
    d0 <= 1'h0;
    apb(1'h1, tpso_pkg::REG_CTRL, {24'h0, 1'h0, 1'h1, 1'h0, pol, tpso_pkg::FMT_LSB_MSB, 2'h0});
    repeat (20) @(posedge clock);
    sw_shut <= 1'h1;
    @(posedge clock);
    sw_shut <= 1'h0;
    n = 0;
    while (link.row_valid_line !== 1'h1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    while (link.row_valid_line !== 1'h0 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      test_done();
    end
    // freeze both ends in the row gap
    ce <= 1'h0;
    @(posedge clock);
    p = link.pixel_clock_out;
    repeat (8) @(posedge clock);
    chk({busy, link.frame_valid_line, link.pixel_clock_out}, {2'h3, p});
    ce <= 1'h1;
    rate <= tpso_pkg::RATE_10;
    n = 0;
    while (link.pixel_clock_out !== 1'h0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    while (link.pixel_clock_out !== 1'h1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      test_done();
    end
    n = 0;
    while (link.pixel_clock_out !== 1'h0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    chk(n, tpso_pkg::CLK_MHZ / (2 * tpso_pkg::PCLK_MHZ_10));
    chk(busy, 1'h1);
    sys_rst <= 1'h1;
    repeat (12) @(posedge clock);
    exp_q.delete();
    sys_rst <= 1'h0;
    @(posedge clock);
    apb(1'h0, tpso_pkg::REG_CTRL, 32'h0);
    chk(rd, {24'h0, tpso_pkg::CTRL_RST});
  endtask
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  initial begin
    {sys_rst, xovf, pol} = 3'h7;
    {d0, ones, sw_shut, psel, penable, pwrite} = 6'h0;
    {paddr, pwdata, k, rv_q} = 53'h0;
    fmt = tpso_pkg::FMT_MSB_LSB;
    repeat (12) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    t_regs();
    t_frame(tpso_pkg::FMT_MSB_LSB, 1'h0, 1'h1);
    t_frame(tpso_pkg::FMT_8BIT, 1'h0, 1'h0);
    t_abort();
    test_done();
  end
endmodule
